// >>> core/uart_fifo_pkg.sv
// Purpose: Shared constants, types and decoders for the UART FIFO block.
// Assumes: One 8-bit character per FIFO entry, bit timing from one clock.
// Notes: Field positions follow the FIFO and line control byte layouts.
package uart_fifo_pkg;
	// FIFO geometry and level counter width.
	localparam int FIFO_DEPTH = 64;
	localparam int DATA_W = 8;
	localparam int LEVEL_W = 7;
	localparam logic [LEVEL_W-1:0] FULL_CAP = 7'h40;
	localparam logic [LEVEL_W-1:0] SINGLE_CAP = 7'h01;
	// System clock cycles per serial bit; baud generation lives elsewhere.
	localparam int CLKS_PER_BIT = 16;
	// FIFO reset settles within this many crystal clock periods.
	localparam int FIFO_RESET_CLKS = 2;
	// Field positions of the FIFO control byte.
	localparam int CTL_RX_TRIG_LSB = 6;
	localparam int CTL_TX_TRIG_LSB = 4;
	localparam int CTL_TX_FLUSH_BIT = 2;
	localparam int CTL_RX_FLUSH_BIT = 1;
	localparam int CTL_ENABLE_BIT = 0;
	localparam logic [7:0] CTL_RESET = 8'h00;
	// Field positions of the line control byte.
	localparam int FMT_WLEN_LSB = 0;
	localparam int FMT_STOP_BIT = 2;
	localparam int FMT_PAR_EN_BIT = 3;
	localparam int FMT_PAR_EVEN_BIT = 4;
	localparam int FMT_PAR_FORCE_BIT = 5;
	localparam int FMT_BREAK_BIT = 6;
	// Shortest word length, selected by a word length code of zero.
	localparam logic [3:0] WLEN_BASE = 4'h5;
	// Stop length in half bits: one, one and a half, two.
	localparam logic [2:0] STOP_HALVES_1 = 3'h2;
	localparam logic [2:0] STOP_HALVES_15 = 3'h3;
	localparam logic [2:0] STOP_HALVES_2 = 3'h4;
	// Receive trigger levels in characters.
	localparam logic [LEVEL_W-1:0] RX_TRIG_0 = 7'h08;
	localparam logic [LEVEL_W-1:0] RX_TRIG_1 = 7'h10;
	localparam logic [LEVEL_W-1:0] RX_TRIG_2 = 7'h38;
	localparam logic [LEVEL_W-1:0] RX_TRIG_3 = 7'h3C;
	// Transmit trigger levels in free spaces.
	localparam logic [LEVEL_W-1:0] TX_TRIG_0 = 7'h08;
	localparam logic [LEVEL_W-1:0] TX_TRIG_1 = 7'h10;
	localparam logic [LEVEL_W-1:0] TX_TRIG_2 = 7'h20;
	localparam logic [LEVEL_W-1:0] TX_TRIG_3 = 7'h38;

	// Serial engine states, shared by receiver and transmitter.
	typedef enum logic [2:0] {
		SER_IDLE, SER_START, SER_DATA, SER_PARITY, SER_STOP
	} ser_state_t;

	// Receive trigger code to a character count.
	function automatic logic [LEVEL_W-1:0] rx_level_of(input logic [1:0] s);
		case (s)
			2'h0: rx_level_of = RX_TRIG_0;
			2'h1: rx_level_of = RX_TRIG_1;
			2'h2: rx_level_of = RX_TRIG_2;
			default: rx_level_of = RX_TRIG_3;
		endcase
	endfunction

	// Transmit trigger code to a count of free spaces.
	function automatic logic [LEVEL_W-1:0] tx_level_of(input logic [1:0] s);
		case (s)
			2'h0: tx_level_of = TX_TRIG_0;
			2'h1: tx_level_of = TX_TRIG_1;
			2'h2: tx_level_of = TX_TRIG_2;
			default: tx_level_of = TX_TRIG_3;
		endcase
	endfunction
endpackage

// >>> core/char_fifo.sv
// Purpose: Character FIFO with flush and a one-entry mode.
// Assumes: DEPTH is a power of two; pointers wrap naturally.
// Notes: A write into a full FIFO is dropped, never stalled or overwritten.
`timescale 1ns/1ps
`default_nettype none
module char_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 64,
	parameter int CNT_W = 7
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic srst,
	// Control.
	input wire logic flush,
	input wire logic single_mode,
	// Fill side.
	input wire logic wr_valid,
	input wire logic [WIDTH-1:0] wr_data,
	output logic wr_ready,
	// Drain side.
	input wire logic rd_en,
	output logic rd_valid,
	output logic [WIDTH-1:0] rd_data,
	output logic [CNT_W-1:0] count
);
	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];      // Character storage.
	logic [PTR_W-1:0] wp_q, wp_d;       // Write pointer.
	logic [PTR_W-1:0] rp_q, rp_d;       // Read pointer.
	logic [CNT_W-1:0] cnt_q, cnt_d;     // Fill level.
	logic [CNT_W-1:0] cap;              // Capacity in the present mode.
	logic push, pop;
	logic [PTR_W-1:0] wr_addr;          // Entry zero only in one-entry mode.

	assign cap = single_mode ? CNT_W'(1) : CNT_W'(DEPTH);
	assign wr_ready = (cnt_q < cap);
	assign rd_valid = (cnt_q != '0);
	assign push = wr_valid && wr_ready;
	assign pop = rd_en && rd_valid;
	assign wr_addr = single_mode ? '0 : wp_q;
	assign rd_data = mem[single_mode ? '0 : rp_q];
	assign count = cnt_q;

	// Next pointers and level; flush discards every stored character.
	always_comb begin
		wp_d = wp_q;
		rp_d = rp_q;
		cnt_d = cnt_q;
		if (flush) begin
			wp_d = '0;
			rp_d = '0;
			cnt_d = '0;
		end else begin
			if (push) begin
				wp_d = single_mode ? '0 : PTR_W'(wp_q + 1'b1);
			end
			if (pop) begin
				rp_d = single_mode ? '0 : PTR_W'(rp_q + 1'b1);
			end
			cnt_d = CNT_W'(cnt_q + CNT_W'(push) - CNT_W'(pop));
		end
	end

	// Pointer and level registers.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage is not reset; a write is harmless while flushing.
	always_ff @(posedge sys_clk) begin
		if (push && !flush) begin
			mem[wr_addr] <= wr_data;
		end
	end
endmodule
`default_nettype wire

// >>> core/uart_fifo_control.sv
// What this block does
// - Receive shifter feeds 64-byte receive FIFO.
// - FIFOs off: receive uses entry zero only.
// - Transmit FIFO feeds shifter onto transmit pin.
// - FIFOs off: transmit byte still stored first.
// - Character arriving at full FIFO is dropped.
// - Receive framing follows line control settings.
// - FIFO control register is write only.
// - Bits 7:6 pick receive trigger 8/16/56/60.
// - Bits 5:4 pick transmit trigger 8/16/32/56.
// - Transmit trigger pick only with enhanced functions enabled; else 8.
// - Bit 2 flushes transmit FIFO, not shifter.
// - Bit 1 flushes receive FIFO, not shifter.
// - Reset bits self-clear; writing zero does nothing.
// - Bit 0 enables both FIFOs; resets to 0.
//
// Purpose: UART receive and transmit FIFOs with their control register.
// Assumes: sys_clk is the crystal clock; CLKS_PER_BIT sets the bit time.
// Notes: Receiver waits out one stop bit unchecked; parity is skipped, not checked.
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_control
	import uart_fifo_pkg::*;
#(
	parameter int CLKS_PER_BIT_P = uart_fifo_pkg::CLKS_PER_BIT
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic srst,
	// FIFO control register write port.
	input wire logic fifo_control_wr,
	input wire logic [7:0] fifo_control_wdata,
	// Line format and enhanced feature settings.
	input wire logic [7:0] line_control_reg,
	input wire logic enhanced_function_enable,
	// Receive holding FIFO read port.
	input wire logic rx_rd,
	output logic [7:0] rx_data,
	// Transmit holding FIFO write port.
	input wire logic tx_wr,
	input wire logic [7:0] tx_wdata,
	// Serial pins.
	input wire logic rx_pin,
	output logic tx_pin,
	// Levels and triggers.
	output logic [uart_fifo_pkg::LEVEL_W-1:0] rx_level,
	output logic [uart_fifo_pkg::LEVEL_W-1:0] tx_space,
	output logic rx_trigger,
	output logic tx_trigger,
	output logic rx_reset_busy,
	output logic tx_reset_busy
);
	import uart_fifo_pkg::*;

	localparam int TMR_W = $clog2(CLKS_PER_BIT_P * 2 + 1);
	localparam logic [TMR_W-1:0] BIT_T = TMR_W'(CLKS_PER_BIT_P - 1);
	localparam logic [TMR_W-1:0] HALF_T = TMR_W'(CLKS_PER_BIT_P / 2 - 1);
	localparam logic [TMR_W-1:0] HALF_BIT = TMR_W'(CLKS_PER_BIT_P / 2);

	// Control register fields; nothing here is readable by the host.
	logic [1:0] rx_trig_q, rx_trig_d;   // Receive trigger code.
	logic [1:0] tx_trig_q, tx_trig_d;   // Transmit trigger code.
	logic en_q, en_d;                   // FIFO enable.
	logic rxr_q, rxr_d;                 // Receive flush pending.
	logic txr_q, txr_d;                 // Transmit flush pending.

	// Line format decode.
	logic [3:0] wlen;                   // Data bits per character.
	logic par_en, par_bit;              // Parity enable and parity value.

	// FIFO ports.
	logic rx_push, rx_ready, rx_valid, tx_pop, tx_valid;
	logic [7:0] rx_head, tx_head;
	logic [LEVEL_W-1:0] rx_cnt, tx_cnt, cap;

	// Receiver state.
	ser_state_t rs_q, rs_d;
	logic [TMR_W-1:0] rt_q, rt_d;       // Receive bit timer.
	logic [3:0] ri_q, ri_d;             // Receive bit index.
	logic [7:0] rx_shift_reg_q, rx_shift_reg_d;
	logic rx_m_q, rx_s_q, rx_prev_q;    // Pin synchroniser and edge history.

	// Transmitter state.
	ser_state_t ts_q, ts_d;
	logic [TMR_W-1:0] tt_q, tt_d;       // Transmit bit timer.
	logic [3:0] ti_q, ti_d;             // Transmit bit index or stop halves.
	logic [7:0] tx_shift_reg_q, tx_shift_reg_d;
	logic line_q, line_d;               // Serial line before break forcing.
	logic [7:0] rx_data_q, rx_data_d;

	assign wlen = WLEN_BASE + {2'h0, line_control_reg[FMT_WLEN_LSB +: 2]};
	assign par_en = line_control_reg[FMT_PAR_EN_BIT];

	// Parity of the shifted character, or forced one/zero.
	function automatic logic parity_of(input logic [7:0] c,
		input logic [7:0] fmt);
		if (fmt[FMT_PAR_FORCE_BIT]) begin
			parity_of = !fmt[FMT_PAR_EVEN_BIT];
		end else begin
			parity_of = (^c) ^ !fmt[FMT_PAR_EVEN_BIT];
		end
	endfunction
	assign par_bit = parity_of(tx_shift_reg_q, line_control_reg);

	// Control register: only writes land here, so no read path exists.
	always_comb begin
		rx_trig_d = rx_trig_q;
		tx_trig_d = tx_trig_q;
		en_d = en_q;
		// A pending flush is applied for one cycle, then clears itself.
		rxr_d = 1'b0;
		txr_d = 1'b0;
		if (fifo_control_wr) begin
			rx_trig_d = fifo_control_wdata[CTL_RX_TRIG_LSB +: 2];
			en_d = fifo_control_wdata[CTL_ENABLE_BIT];
			if (enhanced_function_enable) begin
				tx_trig_d = fifo_control_wdata[CTL_TX_TRIG_LSB +: 2];
			end
			// A new request wins over the self-clear of an older one.
			if (fifo_control_wdata[CTL_RX_FLUSH_BIT]) begin
				rxr_d = 1'b1;
			end
			if (fifo_control_wdata[CTL_TX_FLUSH_BIT]) begin
				txr_d = 1'b1;
			end
		end
	end

	// Control registers.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rx_trig_q <= CTL_RESET[CTL_RX_TRIG_LSB +: 2];
			tx_trig_q <= CTL_RESET[CTL_TX_TRIG_LSB +: 2];
			en_q <= CTL_RESET[CTL_ENABLE_BIT];
			rxr_q <= 1'b0;
			txr_q <= 1'b0;
		end else begin
			rx_trig_q <= rx_trig_d;
			tx_trig_q <= tx_trig_d;
			en_q <= en_d;
			rxr_q <= rxr_d;
			txr_q <= txr_d;
		end
	end

	// Receive holding FIFO; flush touches only this, not the shifter.
	char_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .CNT_W(LEVEL_W)) rx_fifo (
		.sys_clk(sys_clk),
		.srst(srst),
		.flush(rxr_q),
		.single_mode(!en_q),
		.wr_valid(rx_push),
		.wr_data(rx_shift_reg_q),
		.wr_ready(rx_ready),
		.rd_en(rx_rd),
		.rd_valid(rx_valid),
		.rd_data(rx_head),
		.count(rx_cnt)
	);

	// Transmit holding FIFO; host writes are dropped when it is full.
	char_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .CNT_W(LEVEL_W)) tx_fifo (
		.sys_clk(sys_clk),
		.srst(srst),
		.flush(txr_q),
		.single_mode(!en_q),
		.wr_valid(tx_wr),
		.wr_data(tx_wdata),
		.wr_ready(),
		.rd_en(tx_pop),
		.rd_valid(tx_valid),
		.rd_data(tx_head),
		.count(tx_cnt)
	);

	// Receiver: start bit hunt, mid-bit sampling, push at the stop bit.
	always_comb begin
		rs_d = rs_q;
		rt_d = (rt_q != '0) ? TMR_W'(rt_q - 1'b1) : rt_q;
		ri_d = ri_q;
		rx_shift_reg_d = rx_shift_reg_q;
		rx_push = 1'b0;
		case (rs_q)
			SER_IDLE: begin
				if (rx_prev_q && !rx_s_q) begin
					rs_d = SER_START;
					rt_d = HALF_T;
				end
			end
			SER_START: begin
				// A glitch shorter than half a bit is not a start bit.
				if (rt_q == '0) begin
					rs_d = rx_s_q ? SER_IDLE : SER_DATA;
					rt_d = BIT_T;
					ri_d = '0;
					rx_shift_reg_d = '0;
				end
			end
			SER_DATA: begin
				if (rt_q == '0) begin
					rx_shift_reg_d[ri_q[2:0]] = rx_s_q;
					rt_d = BIT_T;
					ri_d = ri_q + 4'h1;
					if (ri_q + 4'h1 == wlen) begin
						rs_d = par_en ? SER_PARITY : SER_STOP;
					end
				end
			end
			SER_PARITY: begin
				if (rt_q == '0) begin
					rs_d = SER_STOP;
					rt_d = BIT_T;
				end
			end
			SER_STOP: begin
				// The finished character moves to the FIFO or is lost.
				if (rt_q == '0) begin
					rx_push = rx_ready;
					rs_d = SER_IDLE;
				end
			end
			default: rs_d = SER_IDLE;
		endcase
	end

	// Receiver registers and a two-stage pin synchroniser.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rs_q <= SER_IDLE;
			rt_q <= '0;
			ri_q <= '0;
			rx_shift_reg_q <= '0;
			rx_m_q <= 1'b1;
			rx_s_q <= 1'b1;
			rx_prev_q <= 1'b1;
		end else begin
			rs_q <= rs_d;
			rt_q <= rt_d;
			ri_q <= ri_d;
			rx_shift_reg_q <= rx_shift_reg_d;
			rx_m_q <= rx_pin;
			rx_s_q <= rx_m_q;
			rx_prev_q <= rx_s_q;
		end
	end

	// Transmitter: pops one character when idle, then frames it.
	always_comb begin
		ts_d = ts_q;
		tt_d = (tt_q != '0) ? TMR_W'(tt_q - 1'b1) : tt_q;
		ti_d = ti_q;
		tx_shift_reg_d = tx_shift_reg_q;
		line_d = line_q;
		tx_pop = 1'b0;
		case (ts_q)
			SER_IDLE: begin
				line_d = 1'b1;
				if (tx_valid) begin
					tx_pop = 1'b1;
					tx_shift_reg_d = tx_head;
					ts_d = SER_START;
					tt_d = BIT_T;
					line_d = 1'b0;
				end
			end
			SER_START: begin
				if (tt_q == '0) begin
					ts_d = SER_DATA;
					tt_d = BIT_T;
					ti_d = '0;
					line_d = tx_shift_reg_q[0];
				end
			end
			SER_DATA: begin
				if (tt_q == '0) begin
					tt_d = BIT_T;
					ti_d = ti_q + 4'h1;
					line_d = tx_shift_reg_q[ti_d[2:0]];
					if (ti_q + 4'h1 == wlen) begin
						ts_d = par_en ? SER_PARITY : SER_STOP;
						line_d = par_en ? par_bit : 1'b1;
						if (!par_en) begin
							tt_d = TMR_W'(HALF_BIT - 1'b1);
							ti_d = {1'b0, stop_halves()};
						end
					end
				end
			end
			SER_PARITY: begin
				if (tt_q == '0) begin
					ts_d = SER_STOP;
					tt_d = TMR_W'(HALF_BIT - 1'b1);
					ti_d = {1'b0, stop_halves()};
					line_d = 1'b1;
				end
			end
			SER_STOP: begin
				// Stop time is counted in half bits to allow one and a half.
				if (tt_q == '0) begin
					tt_d = TMR_W'(HALF_BIT - 1'b1);
					ti_d = ti_q - 4'h1;
					if (ti_q == 4'h1) begin
						ts_d = SER_IDLE;
					end
				end
			end
			default: ts_d = SER_IDLE;
		endcase
	end

	// Stop length from the stop select bit and the word length.
	function automatic logic [2:0] stop_halves();
		if (!line_control_reg[FMT_STOP_BIT]) begin
			stop_halves = STOP_HALVES_1;
		end else if (wlen == WLEN_BASE) begin
			stop_halves = STOP_HALVES_15;
		end else begin
			stop_halves = STOP_HALVES_2;
		end
	endfunction

	// Capacity and the host-side receive data latch.
	assign cap = en_q ? FULL_CAP : SINGLE_CAP;
	assign rx_data_d = (rx_rd && rx_valid) ? rx_head : rx_data_q;

	// Transmitter, host data and status registers.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ts_q <= SER_IDLE;
			tt_q <= '0;
			ti_q <= '0;
			tx_shift_reg_q <= '0;
			line_q <= 1'b1;
			tx_pin <= 1'b1;
			rx_data_q <= '0;
			rx_level <= '0;
			tx_space <= '0;
			rx_trigger <= 1'b0;
			tx_trigger <= 1'b0;
			rx_reset_busy <= 1'b0;
			tx_reset_busy <= 1'b0;
		end else begin
			ts_q <= ts_d;
			tt_q <= tt_d;
			ti_q <= ti_d;
			tx_shift_reg_q <= tx_shift_reg_d;
			line_q <= line_d;
			// Break holds the line low whatever the shifter does.
			tx_pin <= line_d && !line_control_reg[FMT_BREAK_BIT];
			rx_data_q <= rx_data_d;
			rx_level <= rx_cnt;
			tx_space <= (tx_cnt >= cap) ? '0 : LEVEL_W'(cap - tx_cnt);
			rx_trigger <= (rx_cnt >= rx_level_of(rx_trig_q));
			// Without enhanced functions the default code 00 applies.
			tx_trigger <= (LEVEL_W'(cap - tx_cnt) >= tx_level_of(
				enhanced_function_enable ? tx_trig_q : 2'h0)) &&
				(tx_cnt <= cap);
			rx_reset_busy <= rxr_d;
			tx_reset_busy <= txr_d;
		end
	end

	assign rx_data = rx_data_q;
endmodule
`default_nettype wire

// >>> verification/uart_fifo_control_checker.sv
// Purpose: Port-level checks of the UART FIFO block.
// Assumes: One clock; srst is synchronous and active high.
// Notes: Triggers and levels are registered on one edge, so floors are exact.
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_control_checker
	import uart_fifo_pkg::*;
(
	// Clock, reset and control write.
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic fifo_control_wr,
	input wire logic [7:0] fifo_control_wdata,
	// Watched outputs.
	input wire logic [uart_fifo_pkg::LEVEL_W-1:0] rx_level,
	input wire logic [uart_fifo_pkg::LEVEL_W-1:0] tx_space,
	input wire logic rx_trigger,
	input wire logic tx_trigger,
	input wire logic rx_reset_busy,
	input wire logic tx_reset_busy
);
	// One domain, so one clock and one disable for all.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	// A flush write gives exactly one busy cycle.
	a_rx_flush_pulse: assert property (
		fifo_control_wr && fifo_control_wdata[CTL_RX_FLUSH_BIT]
		|=> rx_reset_busy ##1 !rx_reset_busy) else $error("rx busy pulse");
	a_tx_flush_pulse: assert property (
		fifo_control_wr && fifo_control_wdata[CTL_TX_FLUSH_BIT]
		|=> tx_reset_busy ##1 !tx_reset_busy) else $error("tx busy pulse");
	// Without a written one there is no flush at all.
	a_rx_no_flush: assert property (
		!(fifo_control_wr && fifo_control_wdata[CTL_RX_FLUSH_BIT])
		|=> !rx_reset_busy) else $error("rx flush without command");
	a_tx_no_flush: assert property (
		!(fifo_control_wr && fifo_control_wdata[CTL_TX_FLUSH_BIT])
		|=> !tx_reset_busy) else $error("tx flush without command");
	// The flushed FIFO shows empty within two cycles.
	a_rx_flush_done: assert property (
		rx_reset_busy |-> ##[1:2] rx_level == 7'h00)
		else $error("rx not emptied");
	a_tx_flush_done: assert property (
		tx_reset_busy |-> ##[1:2] (tx_space == FULL_CAP ||
		tx_space == SINGLE_CAP)) else $error("tx not emptied");
	// Levels never pass the storage size.
	a_rx_level_cap: assert property (
		rx_level <= FULL_CAP) else $error("rx level too high");
	a_tx_space_cap: assert property (
		tx_space <= FULL_CAP) else $error("tx space too high");
	// A trigger needs at least the lowest level.
	a_rx_trig_floor: assert property (
		rx_trigger |-> rx_level >= RX_TRIG_0)
		else $error("rx trigger too early");
	a_tx_trig_floor: assert property (
		tx_trigger |-> tx_space >= TX_TRIG_0)
		else $error("tx trigger too early");
endmodule
bind uart_fifo_control uart_fifo_control_checker checker_inst (
	.sys_clk(sys_clk), .srst(srst), .fifo_control_wr(fifo_control_wr),
	.fifo_control_wdata(fifo_control_wdata), .rx_level(rx_level),
	.tx_space(tx_space), .rx_trigger(rx_trigger), .tx_trigger(tx_trigger),
	.rx_reset_busy(rx_reset_busy), .tx_reset_busy(tx_reset_busy));
`default_nettype wire

// >>> verification/serial_partner.sv
// Purpose: Remote serial device on the receive and transmit lines.
// Assumes: CPB clock cycles per bit, same rate as the block.
// Notes: Decodes only eight data bits, no parity, for the transmit side.
`timescale 1ns/1ps
`default_nettype none
module serial_partner #(
	parameter int CPB = 16
) (
	// Clock.
	input wire logic sys_clk,
	// Lines seen from the far end.
	input wire logic tx_pin,
	output logic rx_pin
);
	// Characters decoded from the transmit line.
	logic [7:0] got [$];
	logic [7:0] sh;
	initial rx_pin = 1'b1;
	// Holds one bit level for a full bit time.
	task automatic bit_out(input logic b);
		@(negedge sys_clk);
		rx_pin = b;
		repeat (CPB - 1) @(negedge sys_clk);
	endtask
	// Sends one frame, LSB first, shaped by a line control byte.
	task automatic send(input logic [7:0] d, input logic [7:0] fmt);
		int n;
		logic p;
		n = 5 + fmt[1:0];
		p = fmt[5] ? ~fmt[4] : ((^(d & ((8'h01 << n) - 8'h01))) ^ ~fmt[4]);
		bit_out(1'b0);
		for (int i = 0; i < n; i++) bit_out(d[i]);
		if (fmt[3]) bit_out(p);
		bit_out(1'b1);
		if (fmt[2]) bit_out(1'b1);
	endtask
	// Samples transmit frames at mid-bit; bad stop bits are dropped.
	initial begin
		forever begin
			@(negedge tx_pin);
			repeat (CPB / 2) @(posedge sys_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (CPB) @(posedge sys_clk);
				sh[i] = tx_pin;
			end
			repeat (CPB) @(posedge sys_clk);
			if (tx_pin) got.push_back(sh);
		end
	end
endmodule
`default_nettype wire

// >>> verification/uart_fifo_control_tb.sv
// Purpose: Self-checking bench of the UART FIFO block.
// Assumes: Inputs change on the falling clock edge.
// Notes: A short bit time keeps the run small.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin \
	n_fail++; $display("Error %s expected %0h seen %0h", nm, e, s); end end
module uart_fifo_control_tb;
	localparam int CPB = 16;
	logic sys_clk, srst, fc_wr, efe, rd, wr, rx_pin, tx_pin;
	logic [7:0] fc_d, fmt, wd, rx_data;
	logic [6:0] rx_level, tx_space;
	logic rx_trigger, tx_trigger, rx_busy, tx_busy;
	int n_fail = 0;
	int checks_done = 0;
	uart_fifo_control #(.CLKS_PER_BIT_P(CPB)) uart_fifo_control_inst (
		.sys_clk(sys_clk), .srst(srst), .fifo_control_wr(fc_wr),
		.fifo_control_wdata(fc_d), .line_control_reg(fmt),
		.enhanced_function_enable(efe), .rx_rd(rd), .rx_data(rx_data),
		.tx_wr(wr), .tx_wdata(wd), .rx_pin(rx_pin), .tx_pin(tx_pin),
		.rx_level(rx_level), .tx_space(tx_space), .rx_trigger(rx_trigger),
		.tx_trigger(tx_trigger), .rx_reset_busy(rx_busy),
		.tx_reset_busy(tx_busy));
	serial_partner #(.CPB(CPB)) serial_partner_inst (.sys_clk(sys_clk),
		.tx_pin(tx_pin), .rx_pin(rx_pin));
	// Free-running 250 MHz clock.
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Receive trigger table in characters.
	function automatic int rlv(input int c);
		return c == 0 ? 8 : c == 1 ? 16 : c == 2 ? 56 : 60;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// One control write strobe.
	task automatic ctl(input logic [7:0] d);
		@(negedge sys_clk);
		fc_wr = 1'b1;
		fc_d = d;
		@(negedge sys_clk);
		fc_wr = 1'b0;
	endtask
	// Flush, then keep off the data ports for two cycles.
	task automatic flush(input logic [7:0] d);
		ctl(d);
		// The busy flags stand for the single cycle after the write.
		`CHK("rx busy", d[1], rx_busy)
		`CHK("tx busy", d[2], tx_busy)
		cyc(2);
		`CHK("rx busy end", 1'b0, rx_busy)
		`CHK("tx busy end", 1'b0, tx_busy)
	endtask
	// Pops one character; the data is settled one cycle later.
	task automatic pop;
		@(negedge sys_clk);
		rd = 1'b1;
		@(negedge sys_clk);
		rd = 1'b0;
		cyc(1);
	endtask
	// Bounded wait for a free-space value; a miss is a mismatch.
	task automatic wait_space(input logic [6:0] v);
		int k;
		for (k = 0; k < 6000 && tx_space !== v; k++) cyc(1);
		`CHK("space wait", v, tx_space)
	endtask
	task automatic report_and_stop;
		if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Cuts a hang short well past the expected run time.
	initial begin
		#400000;
		n_fail++;
		report_and_stop();
	end
	initial begin
		int cnt, c, n;
		logic [7:0] v, a;
		logic [7:0] q [$];
		logic [7:0] tq [$];
		logic [7:0] fr [4];
		srst = 1'b1;
		{fc_wr, efe, rd, wr} = 4'h0;
		{fc_d, wd} = 16'h0000;
		fmt = 8'h03;
		fr = '{8'h04, 8'h0D, 8'h1A, 8'h2B};
		v = $urandom(64439);
		cyc(3);
		srst = 1'b0;
		cyc(1);
		`CHK("tx_pin", 1'b1, tx_pin);
		`CHK("tx_space", 7'h01, tx_space);
		// FIFOs off: one entry only, extra character lost.
		a = $urandom;
		serial_partner_inst.send(a, fmt);
		serial_partner_inst.send(~a, fmt);
		cyc(3);
		`CHK("rx_level", 7'h01, rx_level);
		pop();
		`CHK("rx_data", a, rx_data);
		@(negedge sys_clk);
		wr = 1'b1;
		wd = $urandom;
		tq.push_back(wd);
		@(negedge sys_clk);
		wr = 1'b0;
		cyc(200);
		// Framing variants: lengths, parity kinds, stop lengths.
		foreach (fr[i]) begin
			fmt = fr[i];
			v = $urandom;
			serial_partner_inst.send(v, fmt);
			cyc(3);
			pop();
			// Bits above the word length arrive as zero.
			a = 8'hFF >> (3 - fmt[1:0]);
			`CHK("framed", v & a, rx_data)
		end
		fmt = 8'h03;
		// Overfill, then drain under random trigger codes.
		ctl(8'h01);
		for (int i = 0; i < 66; i++) begin
			v = $urandom;
			if (i < 64) q.push_back(v);
			serial_partner_inst.send(v, fmt);
		end
		cyc(3);
		`CHK("rx full", 7'h40, rx_level);
		for (cnt = 64; cnt > 0; cnt--) begin
			c = $urandom % 4;
			ctl({c[1:0], 6'h01});
			cyc(3);
			`CHK("rx_level", 7'(cnt), rx_level);
			`CHK("rx_trigger", cnt >= rlv(c), rx_trigger);
			pop();
			`CHK("rx_data", q.pop_front(), rx_data);
		end
		// Flush while a character is still arriving.
		serial_partner_inst.send(8'h5A, fmt);
		v = $urandom;
		fork
			serial_partner_inst.send(v, fmt);
		join_none
		cyc(5 * CPB);
		flush(8'h03);
		`CHK("rx flushed", 7'h00, rx_level);
		wait fork;
		cyc(3);
		`CHK("rx kept", 7'h01, rx_level);
		pop();
		`CHK("rx char", v, rx_data);
		// Transmit burst past capacity.
		efe = 1'b1;
		for (int i = 0; i < 70; i++) begin
			@(negedge sys_clk);
			wr = 1'b1;
			wd = $urandom;
			if (i < 65) tq.push_back(wd);
		end
		@(negedge sys_clk);
		wr = 1'b0;
		cyc(2);
		`CHK("tx full", 7'h00, tx_space);
		`CHK("tx_trigger", 1'b0, tx_trigger);
		wait_space(7'h14);
		ctl(8'h11);
		cyc(3);
		`CHK("tx trig 16", 1'b1, tx_trigger);
		ctl(8'h21);
		cyc(3);
		`CHK("tx trig 32", 1'b0, tx_trigger);
		efe = 1'b0;
		ctl(8'h01);
		cyc(3);
		`CHK("tx trig off", 1'b1, tx_trigger);
		efe = 1'b1;
		cyc(3);
		`CHK("tx trig kept", 1'b0, tx_trigger);
		// Flush while the shifter is mid-character.
		wait_space(7'h15);
		n = serial_partner_inst.got.size();
		flush(8'h05);
		`CHK("tx flushed", 7'h40, tx_space);
		cyc(25 * CPB);
		`CHK("tx count", n + 1, serial_partner_inst.got.size());
		for (int i = 0; i <= n; i++) begin
			a = serial_partner_inst.got[i];
			`CHK("tx char", tq[i], a)
		end
		// Break forces the idle transmit line low until it is lifted.
		fmt = 8'h43;
		cyc(2);
		`CHK("break", 1'b0, tx_pin)
		fmt = 8'h03;
		cyc(2);
		`CHK("break end", 1'b1, tx_pin)
		report_and_stop();
	end
endmodule
`default_nettype wire
